// >>> include/scx_pkg.sv
// Purpose: shared constants and types for the soft core execute slice
// Assumes: 16-bit instruction words, 32-bit data, register window file
// Notes:   offsets and codes are held once here
package scx_pkg;

    localparam int DATA_W   = 32;
    localparam int ADDR_W   = 12;
    localparam int CWP_W    = 5;
    localparam int IDX_W    = 5;
    localparam int LIMM_W   = 11;
    localparam int SIMM_W   = 5;
    localparam int NREG_WIN = 32;

    // instruction encodings
    localparam logic [15:0] OPC_IDLE     = 16'h3000;
    localparam logic [5:0]  OPC_OR       = 6'h10;
    localparam logic [4:0]  OPC_PREFIX   = 5'h13;
    localparam logic [10:0] OPC_INVERT   = 11'h3e0;
    localparam logic [10:0] OPC_CTLREAD  = 11'h3f9;
    localparam logic [10:0] OPC_RLC      = 11'h3e5;
    localparam logic [10:0] OPC_RRC      = 11'h3e6;
    localparam logic [15:0] OPC_POP      = 16'h7da0;
    localparam logic [15:0] OPC_SUBEXIT  = 16'h7fef;

    // register indices
    localparam logic [IDX_W-1:0] GLOBAL_ZERO_IDX = 5'h00;
    localparam logic [IDX_W-1:0] RETURN_LINK_IDX = 5'h1f;

    // control register indices
    localparam logic [LIMM_W-1:0] CTL_STATUS = 11'h000;
    localparam logic [LIMM_W-1:0] CTL_WBOUND = 11'h002;

    // trap numbers
    localparam logic [5:0] TRAP_WIN_OVERFLOW = 6'h02;

    // AHB-Lite register map (byte addresses)
    localparam logic [ADDR_W-1:0] REG_INSTR   = 12'h000;
    localparam logic [ADDR_W-1:0] REG_DATA    = 12'h004;
    localparam logic [ADDR_W-1:0] REG_INDEX   = 12'h008;
    localparam logic [ADDR_W-1:0] REG_RDDATA  = 12'h00c;
    localparam logic [ADDR_W-1:0] REG_FLAGS   = 12'h010;
    localparam logic [ADDR_W-1:0] REG_WINDOW  = 12'h014;
    localparam logic [ADDR_W-1:0] REG_PC      = 12'h018;
    localparam logic [ADDR_W-1:0] REG_IRQ_ST  = 12'h01c;
    localparam logic [ADDR_W-1:0] REG_IRQ_MSK = 12'h020;
    localparam logic [ADDR_W-1:0] REG_PREFIX  = 12'h024;

    // interrupt status bits
    localparam int IRQ_EXEC = 0;
    localparam int IRQ_TRAP = 1;
    localparam int IRQ_W    = 2;

    localparam logic [DATA_W-1:0] RESET_WORD = 32'h0000_0000;

    typedef struct packed {
        logic n;
        logic v;
        logic z;
        logic c;
    } scx_flags_t;

    typedef struct packed {
        logic [CWP_W-1:0] upper;
        logic [CWP_W-1:0] lower;
        logic [CWP_W-1:0] current_window_pointer;
    } scx_window_t;

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_WRITE,
        BUS_READ
    } scx_bus_kind_t;

endpackage

// >>> rtl/scx_alu.sv
// Purpose: combinational result and flag logic for one decoded operation
// Assumes: operands are already fetched from the window register file
// Notes:   flags not named by an operation pass through untouched
`timescale 1ns/1ps
module scx_alu
    import scx_pkg::*;
(
    input  wire logic [15:0]       instr,
    input  wire logic              prefixed,
    input  wire logic [LIMM_W-1:0] prefix_k,
    input  wire logic [DATA_W-1:0] dest_val,
    input  wire logic [DATA_W-1:0] second_val,
    input  wire scx_flags_t        flags_in,
    output logic [DATA_W-1:0]      result,
    output logic                   writes_dest,
    output scx_flags_t             flags_out
);
    logic [DATA_W-1:0] operand_b;

    // second operand: register, or prefix constant above the short immediate [9:5], zero-extended to 32 bits
    always_comb begin
        if (prefixed) begin
            operand_b = {16'h0000, prefix_k, instr[9:5]};
        end else begin
            operand_b = second_val;
        end
    end

    // result and flag selection per opcode
    always_comb begin
        result      = dest_val;
        writes_dest = 1'b0;
        flags_out   = flags_in;
        if (instr[15:10] == OPC_OR) begin
            result      = dest_val | operand_b;
            writes_dest = 1'b1;
            flags_out.n = result[31];
            flags_out.z = (result == RESET_WORD);
        end else if (instr[15:5] == OPC_INVERT) begin
            result      = ~dest_val;
            writes_dest = 1'b1;
        end else if (instr[15:5] == OPC_RLC) begin
            result      = {dest_val[30:0], flags_in.c};
            writes_dest = 1'b1;
            flags_out.c = dest_val[31];
        end else if (instr[15:5] == OPC_RRC) begin
            result      = {flags_in.c, dest_val[31:1]};
            writes_dest = 1'b1;
            flags_out.c = dest_val[0];
        end
    end
endmodule // scx_alu

// >>> rtl/scx_exec.sv
// Purpose: execute slice for logic, prefix, window pop and return ops
// Assumes: software pushes one 16-bit instruction word per bus write
// Notes:   registers reached over AHB-Lite; one level interrupt output
//
// Our own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps

module scx_exec
    import scx_pkg::*;
#(
    parameter int NREG = NREG_WIN
) (
    input  wire logic              sys_clk,
    input  wire logic              rst,
    input  wire logic              hsel,
    input  wire logic [ADDR_W-1:0] haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [DATA_W-1:0] hwdata,
    input  wire logic              hready,
    output logic [DATA_W-1:0]      hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic                   irq,
    output logic                   trap_req,
    output logic [5:0]             trap_num,
    output logic [DATA_W-1:0]      pc
);
    // window register file and architectural state
    logic [DATA_W-1:0] regs [NREG];
    scx_flags_t        flags;
    scx_window_t       win;
    logic [LIMM_W-1:0] prefix_k;
    logic              prefix_valid;
    logic              slot_pending;
    logic [DATA_W-1:0] slot_target;
    logic [IDX_W-1:0]  index_sel;
    logic [DATA_W-1:0] load_data;
    logic [IRQ_W-1:0]  irq_status;
    logic [IRQ_W-1:0]  irq_mask;

    // bus phase capture
    scx_bus_kind_t     bus_kind;
    logic [ADDR_W-1:0] bus_addr;
    logic              exec_fire;
    logic [15:0]       instr;

    // decode; the instruction only counts at the data-phase edge of a write
    // to the instr word, elsewhere these lines follow stray bus data
    logic [IDX_W-1:0]  dest_idx;
    logic [IDX_W-1:0]  src_idx;
    logic [DATA_W-1:0] alu_result;
    logic              alu_writes;
    scx_flags_t        alu_flags;
    logic              is_prefix;
    logic              is_ctlread;
    logic              is_pop;
    logic              is_subexit;
    logic              pop_fault;
    logic [DATA_W-1:0] ctl_value;
    logic [DATA_W-1:0] next_rdata;

    // field split: dest_src_reg in [4:0], second_src_reg or short_immediate
    // in [9:5], long_immediate in [10:0] for the prefix instruction
    assign instr      = hwdata[15:0];
    assign exec_fire  = (bus_kind == BUS_WRITE) && (bus_addr == REG_INSTR);
    assign dest_idx   = instr[4:0];
    assign src_idx    = instr[9:5];
    assign is_prefix  = (instr[15:11] == OPC_PREFIX);
    assign is_ctlread = (instr[15:5] == OPC_CTLREAD);
    assign is_pop     = (instr == OPC_POP);
    assign is_subexit = (instr == OPC_SUBEXIT);
    assign pop_fault  = is_pop && (win.current_window_pointer == win.upper);

    // result and flag logic lives in its own combinational block
    scx_alu u_alu (
        .instr       (instr),
        .prefixed    (prefix_valid),
        .prefix_k    (prefix_k),
        .dest_val    (regs[dest_idx]),
        .second_val  (regs[src_idx]),
        .flags_in    (flags),
        .result      (alu_result),
        .writes_dest (alu_writes),
        .flags_out   (alu_flags)
    );

    // control register select; zero-index default when no prefix
    // only the status word and the window word are backed here; any other
    // index reads zero so a stray prefix cannot leak internal state
    always_comb begin
        ctl_value = RESET_WORD;
        if (prefix_k == CTL_STATUS) begin
            ctl_value = {28'h0000000, flags};
        end else if (prefix_k == CTL_WBOUND) begin
            ctl_value = {17'h00000, win};
        end
    end

    // address phase capture; accesses always complete with no wait state
    // haddr is kept for the data phase because hwdata arrives one cycle late
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bus_kind <= BUS_IDLE;
            bus_addr <= '0;
        end else if (hready) begin
            bus_addr <= haddr;
            if (hsel && htrans[1]) begin
                bus_kind <= hwrite ? BUS_WRITE : BUS_READ;
            end else begin
                bus_kind <= BUS_IDLE;
            end
        end
    end

    // bus answer held in flops: every access is single-cycle and okay, and
    // the output stays registered like every other port of the block
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // register map, one aligned word each, offsets are byte addresses:
    //   instr    write runs hwdata[15:0] as one instruction
    //   data     load latch, read back as written
    //   index    register file index for the access port
    //   rddata   register file word at index; write loads it
    //   flags    {n, v, z, c} in bits 3:0
    //   window   {upper, lower, cwp} in bits 14:0
    //   pc       program counter; a write cancels a pending jump
    //   irq_st   bit 0 instruction done, bit 1 trap; write one clears
    //   irq_msk  same layout as irq_st
    //   prefix   {valid, constant} in bits 11:0
    //   other    reads zero, writes ignored
    // read mux evaluated in the address phase, registered into the data phase
    always_comb begin
        next_rdata = RESET_WORD;
        if (haddr == REG_INDEX) begin
            next_rdata = {27'h0000000, index_sel};
        end else if (haddr == REG_DATA) begin
            next_rdata = load_data;
        end else if (haddr == REG_RDDATA) begin
            next_rdata = regs[index_sel];
        end else if (haddr == REG_FLAGS) begin
            next_rdata = {28'h0000000, flags};
        end else if (haddr == REG_WINDOW) begin
            next_rdata = {17'h00000, win};
        end else if (haddr == REG_PC) begin
            next_rdata = pc;
        end else if (haddr == REG_IRQ_ST) begin
            next_rdata = {30'h00000000, irq_status};
        end else if (haddr == REG_IRQ_MSK) begin
            next_rdata = {30'h00000000, irq_mask};
        end else if (haddr == REG_PREFIX) begin
            next_rdata = {20'h00000, prefix_valid, prefix_k};
        end
    end

    // read data loads only on an accepted read, so it stands until the next
    // read and a write in between cannot disturb it
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            hrdata <= RESET_WORD;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            hrdata <= next_rdata;
        end
    end

    // software-side index and load value for register file access
    // index and load latch are plain storage with no side effect
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            index_sel <= '0;
            load_data <= RESET_WORD;
        end else if (bus_kind == BUS_WRITE) begin
            if (bus_addr == REG_INDEX) begin
                index_sel <= hwdata[IDX_W-1:0];
            end else if (bus_addr == REG_DATA) begin
                load_data <= hwdata;
            end
        end
    end

    // register file: load port, then instruction writeback
    // the load port has priority, as a bus write and an instruction never meet
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NREG; i++) begin
                regs[i] <= RESET_WORD;
            end
        end else if ((bus_kind == BUS_WRITE) && (bus_addr == REG_RDDATA)) begin
            regs[index_sel] <= hwdata;
        end else if (exec_fire && !pop_fault) begin
            if (is_ctlread) begin
                regs[dest_idx] <= prefix_valid ? ctl_value
                                               : {28'h0000000, flags};
            end else if (alu_writes) begin
                regs[dest_idx] <= alu_result;
            end
            // idle op writes global zero with itself: left as a no-write
        end
    end

    // condition flags; ALU passes untouched flags through
    // a bus write to flags and an instruction never share an edge
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            flags <= '0;
        end else if ((bus_kind == BUS_WRITE) && (bus_addr == REG_FLAGS)) begin
            flags <= hwdata[3:0];
        end else if (exec_fire && !pop_fault) begin
            flags <= alu_flags;
        end
    end

    // prefix constant: loaded by prefix, cleared by every other op
    // two prefixes in a row are left to software; the second simply reloads
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prefix_k     <= '0;
            prefix_valid <= 1'b0;
        end else if (exec_fire) begin
            if (is_prefix) begin
                prefix_k     <= instr[10:0];
                prefix_valid <= 1'b1; // back-to-back prefixes simply reload
            end else begin
                prefix_k     <= '0;
                prefix_valid <= 1'b0;
            end
        end
    end

    // window pointer; a faulting pop leaves it where it was
    // the pointer wraps at its width; only the upper bound is policed here
    // a bus write may set the bounds and the pointer in one go
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            win <= '0;
        end else if ((bus_kind == BUS_WRITE) && (bus_addr == REG_WINDOW)) begin
            win <= hwdata[14:0];
        end else if (exec_fire && is_pop && !pop_fault) begin
            win.current_window_pointer <= win.current_window_pointer + 5'h01;
        end
    end

    // trap output: one-cycle request with its number held until next trap
    // the pulse lasts one cycle; exception logic must catch it on that edge
    // trap_num is sticky so exception logic may read it after the pulse
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            trap_req <= 1'b0;
            trap_num <= '0;
        end else begin
            trap_req <= exec_fire && pop_fault;
            if (exec_fire && pop_fault) begin
                trap_num <= TRAP_WIN_OVERFLOW;
            end
        end
    end

    // program counter; jump takes effect after the delay-slot instruction
    // the delay-slot instruction runs first, then the saved target loads
    // a pc write drops any pending jump, so software can restart cleanly
    // a faulting pop holds pc so the exception logic sees the faulting slot
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pc           <= RESET_WORD;
            slot_pending <= 1'b0;
            slot_target  <= RESET_WORD;
        end else if ((bus_kind == BUS_WRITE) && (bus_addr == REG_PC)) begin
            pc           <= hwdata;
            slot_pending <= 1'b0;
        end else if (exec_fire) begin
            if (pop_fault) begin
                pc <= pc; // exception logic takes over
            end else if (is_subexit) begin
                slot_target  <= {regs[RETURN_LINK_IDX][30:0], 1'b0};
                slot_pending <= 1'b1;
                pc           <= pc + 32'h0000_0002;
            end else if (slot_pending) begin
                pc           <= slot_target;
                slot_pending <= 1'b0;
            end else begin
                pc <= pc + 32'h0000_0002;
            end
        end
    end

    // sticky events: set beats a same-cycle write-one clear
    // bit 0 marks a completed instruction; a faulting pop sets only bit 1
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq_status <= '0;
            irq_mask   <= '0;
        end else begin
            if ((bus_kind == BUS_WRITE) && (bus_addr == REG_IRQ_MSK)) begin
                irq_mask <= hwdata[IRQ_W-1:0];
            end
            irq_status <= (irq_status
                           & ~(((bus_kind == BUS_WRITE) && (bus_addr == REG_IRQ_ST))
                               ? hwdata[IRQ_W-1:0] : 2'b00))
                          | {exec_fire && pop_fault, exec_fire && !pop_fault};
        end
    end

    // level interrupt, registered so it comes straight from a flop
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_mask);
        end
    end

    // note: hreadyout and hresp hold fixed values; the bus never waits or errs
    // idle op encoding reaches no ALU branch, so registers and flags stay intact
endmodule // scx_exec

// >>> test/scx_checker.sv
// Purpose: port-level checks for the execute slice
// Assumes: single AHB-Lite slave, hready tied to hreadyout
// Notes:   an instruction runs at the data phase edge of a write to REG_INSTR
`timescale 1ns/1ps
module scx_checker
    import scx_pkg::*;
(
    input wire logic              sys_clk,
    input wire logic              rst,
    input wire logic              hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0]        htrans,
    input wire logic              hwrite,
    input wire logic [2:0]        hsize,
    input wire logic [DATA_W-1:0] hwdata,
    input wire logic              hready,
    input wire logic [DATA_W-1:0] hrdata,
    input wire logic              hreadyout,
    input wire logic              hresp,
    input wire logic              irq,
    input wire logic              trap_req,
    input wire logic [5:0]        trap_num,
    input wire logic [DATA_W-1:0] pc
);
    logic              a_wr;
    logic [ADDR_W-1:0] a_addr;
    wire               take  = hsel && htrans[1] && hready;
    wire               de_wr = a_wr && hready;
    wire               exec  = de_wr && a_addr == REG_INSTR;

    // remember the address phase so the write data edge is known
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            a_wr   <= 1'h0;
            a_addr <= '0;
        end else if (hready) begin
            a_wr   <= take && hwrite;
            a_addr <= haddr;
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    // a single slave with no wait states, always okay
    chk_bus_answer: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    chk_trap_number: assert property (trap_req |-> trap_num == TRAP_WIN_OVERFLOW)
        else $error("trap number wrong");
    chk_trap_cause: assert property (trap_req |-> $past(exec) && $past(hwdata[15:0]) == OPC_POP)
        else $error("trap without a window pop");
    chk_trap_keeps_pc: assert property (trap_req |-> $stable(pc))
        else $error("faulting pop moved pc");
    chk_trap_num_hold: assert property ($changed(trap_num) |-> trap_req)
        else $error("trap number changed without trap");
    chk_exit_step: assert property (exec && hwdata[15:0] == OPC_SUBEXIT |=> pc == $past(pc) + 32'h2)
        else $error("exit jump did not step into delay slot");
    chk_pc_cause: assert property ($changed(pc) |-> $past(de_wr))
        else $error("pc changed without a write");
    chk_rdata_hold: assert property (!$past(take && !hwrite) |-> $stable(hrdata))
        else $error("read data changed without a read");
    chk_irq_fall: assert property ($fell(irq) |-> $past(de_wr, 1) || $past(de_wr, 2))
        else $error("irq dropped without a write");
    chk_irq_rise: assert property ($rose(irq) |-> $past(de_wr, 1) || $past(de_wr, 2))
        else $error("irq rose without a write");

    cov_trap: cover property (trap_req);
    cov_exit: cover property (exec && hwdata[15:0] == OPC_SUBEXIT);
    cov_irq_clear: cover property ($fell(irq));
endmodule // scx_checker

bind scx_exec scx_checker u_chk (.sys_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .irq, .trap_req, .trap_num, .pc);

// >>> test/tb_top.sv
// Purpose: self-checking bench for the execute slice over AHB-Lite
// Assumes: hready tied to hreadyout, one instruction per bus write
// Notes:   reads are scored by a monitor against a queue of expectations
`timescale 1ns/1ps
module tb_top
    import scx_pkg::*;
;
    logic              sys_clk;
    logic              rst;
    logic              hsel;
    logic [ADDR_W-1:0] haddr;
    logic [1:0]        htrans;
    logic              hwrite;
    logic [2:0]        hsize;
    logic [DATA_W-1:0] hwdata;
    logic [DATA_W-1:0] hrdata;
    logic              hreadyout;
    logic              hresp;
    logic              irq;
    logic              trap_req;
    logic [5:0]        trap_num;
    logic [DATA_W-1:0] pc;
    logic [DATA_W-1:0] exp_q[$];
    logic              rd_ph;
    logic [DATA_W-1:0] a, b, r;
    logic [10:0]       k;
    logic [4:0]        m;
    scx_window_t       w;
    int                failures;
    int                compares;
    int                traps;

    scx_exec dut (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .trap_req(trap_req),
        .trap_num(trap_num), .pc(pc));

    initial begin
        sys_clk = 1'h0;
        forever #10 sys_clk = ~sys_clk;
    end

    task automatic chk(input string n, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] s);
        compares++;
        if (s !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask

    // one single transfer; each phase held until hready is seen high
    task automatic bus(input logic wr, input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] d);
        hsel   <= 1'h1;
        haddr  <= ad;
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge sys_clk); while (hreadyout !== 1'h1);
        htrans <= 2'h0;
        hwdata <= wr ? d : $urandom;
        do @(posedge sys_clk); while (hreadyout !== 1'h1);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] e);
        exp_q.push_back(e);
        bus(1'h0, ad, '0);
    endtask

    task automatic wr(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] d);
        bus(1'h1, ad, d);
    endtask

    task automatic setr(input logic [4:0] i, input logic [DATA_W-1:0] v);
        wr(REG_INDEX, {27'h0, i});
        wr(REG_RDDATA, v);
    endtask

    task automatic getr(input logic [4:0] i, input logic [DATA_W-1:0] e);
        wr(REG_INDEX, {27'h0, i});
        rd(REG_RDDATA, e);
    endtask

    task automatic ex(input logic [15:0] ins);
        wr(REG_INSTR, {16'h0, ins});
    endtask

    task automatic close_out;
        if (exp_q.size() != 0) failures++;
        if (failures == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // score each read data phase; an empty queue is itself a mismatch
    always @(posedge sys_clk) begin
        if (rd_ph && hreadyout === 1'h1) begin
            if (exp_q.size() == 0) begin
                chk("queue", 32'h0, 32'h1);
            end else begin
                chk("hrdata", exp_q.pop_front(), hrdata);
            end
        end
        rd_ph = !rst && hsel && htrans[1] && !hwrite && hreadyout;
        if (trap_req === 1'h1) traps++;
    end

    // watchdog: the whole sequence needs well under a few thousand cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        close_out();
    end

    initial begin
        {hsel, haddr, htrans, hwrite, hwdata, rd_ph, failures, compares, traps} = '0;
        hsize = 3'h2;
        rst = 1'h1;
        a = $urandom(32'hcfc3dce7);
        repeat (20) @(posedge sys_clk);
        rst <= 1'h0;
        @(posedge sys_clk);
        rd(REG_PC, 32'h0);
        rd(REG_PREFIX, 32'h0);
        rd(12'h040, 32'h0);
        wr(REG_IRQ_MSK, 32'h0);
        wr(REG_DATA, a);
        rd(REG_DATA, a);
        // register and immediate forms share one opcode; flags v and c preset
        for (int i = 0; i < 4; i++) begin
            a = $urandom & {32{i != 0}};
            b = {i[0], 31'($urandom)} & {32{i != 0}};
            k = 11'($urandom);
            m = 5'($urandom);
            wr(REG_FLAGS, 32'h5);
            setr(5'h1, a);
            setr(5'h2, b);
            ex({OPC_OR, 5'h2, 5'h1});
            r = a | b;
            getr(5'h1, r);
            rd(REG_FLAGS, {28'h0, r[31], 1'h1, r == 0, 1'h1});
            ex({OPC_PREFIX, k});
            rd(REG_PREFIX, {20'h0, 1'h1, k});
            ex({OPC_OR, m, 5'h2});
            getr(5'h2, b | {16'h0, k, m});
            rd(REG_PREFIX, 32'h0);
            wr(REG_FLAGS, 32'ha);
            setr(5'h4, a);
            ex({OPC_INVERT, 5'h4});
            getr(5'h4, ~a);
            rd(REG_FLAGS, 32'ha);
            wr(REG_FLAGS, {28'h0, 3'h5, i[1]});
            setr(5'h5, b);
            ex({OPC_RLC, 5'h5});
            getr(5'h5, {b[30:0], i[1]});
            rd(REG_FLAGS, {28'h0, 3'h5, b[31]});
            ex({OPC_RRC, 5'h5});
            getr(5'h5, b);
            rd(REG_FLAGS, {28'h0, 3'h5, i[1]});
            wr(REG_FLAGS, 32'h6);
            setr(5'h0, a);
            ex(OPC_IDLE);
            getr(5'h0, a);
            rd(REG_FLAGS, 32'h6);
        end
        // control reads: status by default, window word through the prefix
        wr(REG_FLAGS, 32'h9);
        ex({OPC_CTLREAD, 5'h6});
        getr(5'h6, 32'h9);
        w = '{upper: 5'h6, lower: 5'h1, current_window_pointer: 5'h3};
        wr(REG_WINDOW, {17'h0, w});
        ex({OPC_PREFIX, CTL_WBOUND});
        ex({OPC_CTLREAD, 5'h7});
        getr(5'h7, {17'h0, w});
        // three pops reach the bound, the fourth traps and changes nothing
        repeat (3) ex(OPC_POP);
        w.current_window_pointer = 5'h6;
        rd(REG_WINDOW, {17'h0, w});
        wr(REG_IRQ_MSK, 32'h2);
        wr(REG_IRQ_ST, 32'h3);
        rd(REG_IRQ_ST, 32'h0);
        @(negedge sys_clk);
        chk("irq", 32'h0, {31'h0, irq});
        @(posedge sys_clk);
        ex(OPC_POP);
        rd(REG_WINDOW, {17'h0, w});
        rd(REG_IRQ_ST, 32'h2);
        @(negedge sys_clk);
        chk("irq", 32'h1, {31'h0, irq});
        chk("trap_num", {26'h0, TRAP_WIN_OVERFLOW}, {26'h0, trap_num});
        @(posedge sys_clk);
        wr(REG_IRQ_ST, 32'h2);
        rd(REG_IRQ_ST, 32'h0);
        @(negedge sys_clk);
        chk("irq", 32'h0, {31'h0, irq});
        chk("traps", 32'h1, traps);
        @(posedge sys_clk);
        // exit jump: the invert in its slot runs before the target is taken
        a = $urandom;
        setr(5'h1f, a);
        setr(5'h4, b);
        wr(REG_FLAGS, 32'h5);
        wr(REG_PC, 32'h100);
        ex(OPC_SUBEXIT);
        rd(REG_PC, 32'h102);
        ex({OPC_INVERT, 5'h4});
        rd(REG_PC, a << 1);
        getr(5'h4, ~b);
        rd(REG_FLAGS, 32'h5);
        rd(REG_IRQ_ST, 32'h1);
        repeat (2) @(posedge sys_clk);
        close_out();
    end
endmodule // tb_top
